// >>> rtl/dhs_pkg.sv
// dual halfword shifter: shared constants and types
// assumes one core clock domain; no register bus
package dhs_pkg;

    localparam int HALF_W    = 16;
    localparam int WORD_W    = 32;
    localparam int IMM_W     = 4;
    localparam int AMT_W     = 5;
    localparam int INSN_LEN  = 32;
    localparam int HI_LSB    = 16;
    localparam logic [15:0] HALF_MAX_POS = 16'h7fff;
    localparam logic [15:0] HALF_MAX_NEG = 16'h8000;
    localparam logic [15:0] HALF_ZERO    = 16'h0000;
    localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
    localparam logic [4:0]  AMT_ZERO     = 5'h00;
    localparam logic [5:0]  INSN_LEN_CODE = 6'h20;

    // shift operation selected by instruction decode
    typedef enum logic [3:0] {
        DHS_OP_ASR_IMM = 4'b0001,
        DHS_OP_LSR_IMM = 4'b0010,
        DHS_OP_LSL_IMM = 4'b0100,
        DHS_OP_REG     = 4'b1000
    } dhs_op_type;

    // one-hot execute state
    typedef enum logic [1:0] {
        DHS_ST_IDLE = 2'b01,
        DHS_ST_DONE = 2'b10
    } dhs_state_type;

endpackage

// >>> rtl/dhs_half_if.sv
// dual halfword shifter: link between top and per-half lane
// assumes the top drives operands and the lane answers combinationally
`timescale 1ns/10ps
interface dhs_half_if;
    import dhs_pkg::*;
    logic [15:0] operand;
    logic [4:0]  amount;
    logic        toLeft;
    logic        arith;
    logic        saturate;
    logic [15:0] result;
    logic        overflow;

    modport top  (output operand, output amount, output toLeft, output arith, output saturate,
                  input result, input overflow);
    modport lane (input operand, input amount, input toLeft, input arith, input saturate,
                  output result, output overflow);
endinterface

// >>> rtl/dhs_half_lane.sv
// dual halfword shifter: one 16-bit shift lane
// assumes amount is a magnitude of 0 to 16 and direction is given apart
`timescale 1ns/10ps
module dhs_half_lane
    import dhs_pkg::*;
(
    dhs_half_if.lane lnk
);

    logic [31:0] wideLeft;
    logic [15:0] rightArith;
    logic [15:0] rightLogic;
    logic        lostBits;

    always_comb begin
        // sign-extended so the bits above the new sign hold what was pushed out
        wideLeft   = {{HALF_W{lnk.operand[HALF_W-1]}}, lnk.operand} << lnk.amount;
        rightArith = 16'($signed(lnk.operand) >>> lnk.amount);
        rightLogic = lnk.operand >> lnk.amount;
        // the sign holds only if the new sign and every bit pushed past it equal the old sign
        lostBits   = wideLeft[WORD_W-1:HALF_W-1] != {(HALF_W+1){lnk.operand[HALF_W-1]}};
        lnk.overflow = 1'b0;
        if (lnk.toLeft) begin
            lnk.overflow = lostBits;
            if (lnk.saturate && lostBits) begin
                lnk.result = lnk.operand[15] ? HALF_MAX_NEG : HALF_MAX_POS;
            end else begin
                lnk.result = wideLeft[15:0];
            end
        end else if (lnk.arith) begin
            lnk.result = rightArith;
        end else begin
            lnk.result = rightLogic;
        end
        if (!lnk.arith) begin
            lnk.overflow = 1'b0;
        end
    end

endmodule

// >>> rtl/dual_halfword_shifter.sv
// dual halfword shifter: top of the vector shift datapath
// assumes decode presents one operation with a start pulse; result and flags
// come back one cycle later from flops, and the register file writes them back
//
// Function
// - each 16-bit half is shifted at once but alone, with no bit crossing halves.
// - an arithmetic right shift fills vacated top bits with the half's own sign.
// - immediate forms take an unsigned 4-bit distance of 0 to 15.
// - an unsaturated left shift is plain logical and loses bits past bit 15.
// - a saturating left shift that loses non-sign bits returns the signed extreme of the original sign.
// - register arithmetic shift: positive goes left (saturating if asked), negative goes arithmetic right.
// - register amounts are signed -16 to +15 from the low half, upper bits ignored.
// - logical shifts drop bits moved out and fill vacated places with zeros.
// - register logical shift goes left for positive amounts and right for negative ones.
// - zero and negative flags are set if either half is zero or negative; logical shifts clear overflow.
// - arithmetic shifts set overflow if either half overflows, and set sticky overflow with it.
// - no other status flag is touched by a vector shift.
// - the source is changed only when it is also the destination, then it takes the result.
// - every vector shift form decodes as a 32-bit instruction.
`timescale 1ns/10ps
module dual_halfword_shifter
    import dhs_pkg::*;
#(
    parameter int REG_SEL_W = 3
)
(
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    input  wire logic                 start,
    input  wire dhs_op_type           opSel,
    input  wire logic                 arithMode,
    input  wire logic                 saturate,
    input  wire logic [3:0]           imm_shift_amount,
    input  wire logic [15:0]          data_register_low_half,
    input  wire logic [31:0]          srcData,
    input  wire logic [REG_SEL_W-1:0] srcSel,
    input  wire logic [REG_SEL_W-1:0] dstSel,
    input  wire logic                 stickyIn,
    output logic                      resultValid,
    output logic [31:0]               resultData,
    output logic [REG_SEL_W-1:0]      resultSel,
    output logic                      srcOverwritten,
    output logic                      zero_flag,
    output logic                      negative_flag,
    output logic                      overflow_flag,
    output logic                      sticky_overflow_flag,
    output logic                      flagsWrite,
    output logic [5:0]                insnLength
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        dhs_state_type        state;
        logic                 valid;
        logic [31:0]          data;
        logic [REG_SEL_W-1:0] sel;
        logic                 srcHit;
        logic                 zero;
        logic                 neg;
        logic                 ovf;
        logic                 sticky;
    } dhs_regs_type;

    dhs_regs_type st_r;
    dhs_regs_type st_nxt;

    dhs_half_if hiLnk ();
    dhs_half_if loLnk ();

    dhs_half_lane uHi (.lnk(hiLnk.lane));
    dhs_half_lane uLo (.lnk(loLnk.lane));

    ////////////////////////////////////////////////////////////////////////////
    // amount decode

    logic [4:0] regAmt;
    logic [4:0] magnitude;
    logic       goLeft;
    logic       useArith;
    logic       useSat;
    logic       isArithOp;

    always_comb begin
        regAmt    = data_register_low_half[AMT_W-1:0];
        magnitude = AMT_ZERO;
        goLeft    = 1'b0;
        useArith  = 1'b0;
        useSat    = 1'b0;
        isArithOp = 1'b0;
        unique case (opSel)
            DHS_OP_ASR_IMM: begin
                magnitude = {1'b0, imm_shift_amount};
                useArith  = 1'b1;
                isArithOp = 1'b1;
            end
            DHS_OP_LSR_IMM: begin
                magnitude = {1'b0, imm_shift_amount};
            end
            DHS_OP_LSL_IMM: begin
                // saturating left immediate counts as arithmetic for the overflow flag
                magnitude = {1'b0, imm_shift_amount};
                goLeft    = 1'b1;
                useSat    = saturate;
                useArith  = saturate;
                isArithOp = saturate;
            end
            DHS_OP_REG: begin
                isArithOp = arithMode;
                if (regAmt[AMT_W-1]) begin
                    magnitude = 5'(-regAmt);
                    useArith  = arithMode;
                end else begin
                    magnitude = regAmt;
                    goLeft    = 1'b1;
                    useSat    = arithMode && saturate;
                    useArith  = arithMode;
                end
            end
            default: begin
                magnitude = AMT_ZERO;
            end
        endcase
    end

    // both lanes see the same control, each its own half
    assign hiLnk.operand  = srcData[WORD_W-1:HI_LSB];
    assign loLnk.operand  = srcData[HI_LSB-1:0];
    assign hiLnk.amount   = magnitude;
    assign loLnk.amount   = magnitude;
    assign hiLnk.toLeft   = goLeft;
    assign loLnk.toLeft   = goLeft;
    assign hiLnk.arith    = useArith;
    assign loLnk.arith    = useArith;
    assign hiLnk.saturate = useSat;
    assign loLnk.saturate = useSat;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic anyOvf;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.valid = 1'b0;
        // a pulse beside valid, so the output needs no gate after the flop
        st_nxt.srcHit = 1'b0;
        anyOvf       = hiLnk.overflow || loLnk.overflow;
        unique case (st_r.state)
            DHS_ST_IDLE,
            DHS_ST_DONE: begin
                if (start) begin
                    // halves and flags land in the same edge
                    st_nxt.state  = DHS_ST_DONE;
                    st_nxt.valid  = 1'b1;
                    st_nxt.data   = {hiLnk.result, loLnk.result};
                    st_nxt.sel    = dstSel;
                    st_nxt.srcHit = (dstSel == srcSel);
                    st_nxt.zero   = (hiLnk.result == HALF_ZERO) || (loLnk.result == HALF_ZERO);
                    st_nxt.neg    = hiLnk.result[HALF_W-1] || loLnk.result[HALF_W-1];
                    st_nxt.ovf    = isArithOp && anyOvf;
                    // sticky only ever sets; otherwise it echoes the old value
                    st_nxt.sticky = stickyIn || (isArithOp && anyOvf);
                end else begin
                    st_nxt.state = DHS_ST_IDLE;
                end
            end
            default: begin
                st_nxt.state = DHS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{state: DHS_ST_IDLE, valid: 1'b0, data: WORD_ZERO, sel: '0, srcHit: 1'b0,
                      zero: 1'b0, neg: 1'b0, ovf: 1'b0, sticky: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flops but the constant insnLength

    assign resultValid          = st_r.valid;
    assign resultData           = st_r.data;
    assign resultSel            = st_r.sel;
    assign srcOverwritten       = st_r.srcHit;
    assign zero_flag            = st_r.zero;
    assign negative_flag        = st_r.neg;
    assign overflow_flag        = st_r.ovf;
    assign sticky_overflow_flag = st_r.sticky;
    assign flagsWrite           = st_r.valid;   // only these four flags are ever written
    assign insnLength           = INSN_LEN_CODE;

endmodule

// >>> sim/dhs_regfile_model.sv
// register file model feeding the shifter its source word
// assumes write-back comes with resultValid; the bench may inject fresh words
`timescale 1ns/10ps
module dhs_regfile_model (
    input  wire logic        core_clk,
    input  wire logic [2:0]  srcSel,
    input  wire logic [2:0]  dstSel,
    input  wire logic        inject,
    input  wire logic [31:0] injectData,
    input  wire logic        resultValid,
    input  wire logic [2:0]  resultSel,
    input  wire logic [31:0] resultData,
    output logic      [31:0] srcData
);
    logic [31:0] regs [8];
    initial foreach (regs[i]) regs[i] = 32'h8004_000f + i;
    assign srcData = regs[srcSel];
    // write-back last so a result wins over an injected word
    always @(posedge core_clk) begin
        if (inject) regs[dstSel] <= injectData;
        if (resultValid) regs[resultSel] <= resultData;
    end
endmodule

// >>> sim/dhs_props.sv
// checker for the dual halfword shifter top ports
// assumes one core clock and an async active-low reset
`timescale 1ns/10ps
module dhs_props
    import dhs_pkg::*;
#(
    parameter int REG_SEL_W = 3
)
(
    input wire logic                 core_clk,
    input wire logic                 nrst,
    input wire logic                 start,
    input wire dhs_op_type           opSel,
    input wire logic [REG_SEL_W-1:0] srcSel,
    input wire logic [REG_SEL_W-1:0] dstSel,
    input wire logic                 stickyIn,
    input wire logic                 resultValid,
    input wire logic [31:0]          resultData,
    input wire logic [REG_SEL_W-1:0] resultSel,
    input wire logic                 srcOverwritten,
    input wire logic                 zero_flag,
    input wire logic                 negative_flag,
    input wire logic                 overflow_flag,
    input wire logic                 sticky_overflow_flag,
    input wire logic                 flagsWrite,
    input wire logic [5:0]           insnLength
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    a_valid_next: assert property (start |=> resultValid) else $error("no result after start");
    a_no_spurious: assert property (!start |=> !resultValid) else $error("result without start");
    a_flag_strobe: assert property (flagsWrite == resultValid) else $error("flag write apart from result");
    a_dest_sel: assert property (start |=> resultSel == $past(dstSel)) else $error("wrong destination");
    a_src_overwrite: assert property (start |=> srcOverwritten == ($past(srcSel) == $past(dstSel)))
        else $error("source overwrite wrong");
    a_sticky_set: assert property (start |=> sticky_overflow_flag == ($past(stickyIn) | overflow_flag))
        else $error("sticky overflow wrong");
    a_zero_any: assert property (resultValid |-> zero_flag == (resultData[31:16] == 16'h0000
        || resultData[15:0] == 16'h0000)) else $error("zero flag wrong");
    a_neg_any: assert property (resultValid |-> negative_flag == (resultData[31] | resultData[15]))
        else $error("negative flag wrong");
    a_right_no_ovf: assert property (start && (opSel == DHS_OP_ASR_IMM || opSel == DHS_OP_LSR_IMM)
        |=> !overflow_flag) else $error("overflow on right shift");
    a_hold_result: assert property (!start |=> $stable(resultData) && $stable(zero_flag))
        else $error("result moved without start");
    a_insn_len: assert property (insnLength == INSN_LEN_CODE) else $error("length not 32");
endmodule
bind dual_halfword_shifter dhs_props #(.REG_SEL_W(REG_SEL_W)) u_props (.*);

// >>> sim/dual_halfword_shifter_bench.sv
// self-checking bench for the dual halfword shifter
// assumes the register file model supplies srcData and takes write-backs
`timescale 1ns/10ps
module dual_halfword_shifter_bench;
    import dhs_pkg::*;
    logic        core_clk = 0, nrst = 0, start = 0, arithMode = 0, saturate = 0, stickyIn = 0, inject = 0;
    dhs_op_type  opSel = DHS_OP_ASR_IMM;
    logic [3:0]  imm_shift_amount = 4'h0;
    logic [15:0] data_register_low_half = 16'h0000;
    logic [31:0] srcData, resultData, injectData = 32'h0000_0000;
    logic [2:0]  srcSel = 3'h0, dstSel = 3'h0, resultSel;
    logic        resultValid, srcOverwritten, zero_flag, negative_flag, overflow_flag, sticky_overflow_flag;
    logic        flagsWrite;
    logic [5:0]  insnLength;
    logic [41:0] expWord;
    bit          pendPrev = 0;
    int          failures = 0, checksDone = 0;
    always #2 core_clk = ~core_clk;
    dual_halfword_shifter dut (.*);
    dhs_regfile_model partner (.core_clk(core_clk), .srcSel(srcSel), .dstSel(dstSel), .inject(inject),
        .injectData(injectData), .resultValid(resultValid), .resultSel(resultSel), .resultData(resultData),
        .srcData(srcData));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(logic [63:0] seen, logic [63:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && checksDone > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one half: bit 16 is overflow, judged on the bits pushed out and the new sign
    function automatic logic [16:0] half(logic [15:0] x, int n, bit left, bit ar, bit rep, bit sat);
        logic [16:0] r;
        int lost;
        r[16] = 1'b0;
        if (left) begin
            lost = int'(x) >> (15 - n);
            r[15:0] = x << n;
            r[16] = rep && (lost != (x[15] ? (1 << (n + 1)) - 1 : 0));
            if (sat && r[16]) r[15:0] = x[15] ? HALF_MAX_NEG : HALF_MAX_POS;
        end else begin
            r[15:0] = ar ? 16'($signed(x) >>> n) : 16'(x >> n);
        end
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // expectation built at the falling edge, where inputs have settled
    always @(negedge core_clk) begin
        logic [16:0] h, l;
        int n;
        bit left, ar, rep, sat;
        if (nrst) begin
            if (pendPrev) check({resultValid, resultData, zero_flag, negative_flag, overflow_flag,
                sticky_overflow_flag, resultSel, srcOverwritten, flagsWrite}, expWord);
            else check(resultValid, 1'b0);
            pendPrev = start;
            n = imm_shift_amount;
            left = opSel == DHS_OP_LSL_IMM;
            ar = opSel == DHS_OP_ASR_IMM;
            rep = left && saturate;
            sat = rep;
            if (opSel == DHS_OP_REG) begin
                n = $signed(data_register_low_half[4:0]);
                left = n >= 0;
                ar = arithMode;
                rep = left && arithMode;
                sat = rep && saturate;
                if (!left) n = -n;
            end
            h = half(srcData[31:16], n, left, ar, rep, sat);
            l = half(srcData[15:0], n, left, ar, rep, sat);
            expWord = {1'b1, h[15:0], l[15:0], h[15:0] == 16'h0000 || l[15:0] == 16'h0000, h[15] | l[15],
                h[16] | l[16], stickyIn | h[16] | l[16], dstSel, srcSel == dstSel, 1'b1};
        end
    end
    initial begin
        #40000;
        failures++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h563d));
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        check(insnLength, INSN_LEN_CODE);
        // random mix keeps back-to-back starts and idle gaps
        repeat (800) begin
            @(posedge core_clk);
            start <= ($urandom % 4) != 0;
            inject <= ($urandom % 3) == 0;
            injectData <= $urandom;
            opSel <= dhs_op_type'(4'h1 << ($urandom % 4));
            arithMode <= 1'($urandom);
            saturate <= 1'($urandom);
            stickyIn <= 1'($urandom);
            imm_shift_amount <= 4'($urandom);
            data_register_low_half <= 16'($urandom);
            srcSel <= 3'($urandom);
            dstSel <= 3'($urandom);
        end
        @(posedge core_clk);
        start <= 1'b0;
        repeat (3) @(posedge core_clk);
        finish_test();
    end
endmodule
